// ==== cpg_deadtime.sv ====
// cpg_deadtime.sv: complementary pair with dead time on each edge
// assumes pclk domain; raw is the undelayed high drive
`timescale 1ns/10ps
module cpg_deadtime
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     raw,
  input  wire logic [cpg_pkg::CNT_W-1:0] dt_rise,
  input  wire logic [cpg_pkg::CNT_W-1:0] dt_fall,
  output logic                          hi,
  output logic                          lo
);
  logic                      last_reg;
  logic [cpg_pkg::CNT_W-1:0] cnt_reg;
  logic [cpg_pkg::CNT_W-1:0] dt_sel;

  // the count-zero cycle is part of the gap, so the count loads one less
  assign dt_sel = raw ? dt_rise : dt_fall;

  // on each raw change with a nonzero delay both go low, then the new side rises after it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_reg <= 1'b0;
      cnt_reg  <= cpg_pkg::ZERO;
      hi       <= 1'b0;
      lo       <= 1'b0;
    end
    else if (ce)
    begin
      last_reg <= raw;
      if (raw != last_reg)
      begin
        cnt_reg <= (dt_sel == cpg_pkg::ZERO) ? cpg_pkg::ZERO : dt_sel - cpg_pkg::ONE;
        hi      <= raw && (dt_sel == cpg_pkg::ZERO);
        lo      <= !raw && (dt_sel == cpg_pkg::ZERO);
      end
      else if (cnt_reg != cpg_pkg::ZERO)
        cnt_reg <= cnt_reg - cpg_pkg::ONE;
      else
      begin
        hi <= raw;
        lo <= !raw;
      end
    end
  end
endmodule : cpg_deadtime

// ==== cpg_pkg.sv ====
// cpg_pkg.sv: register map, field positions and constants of the pwm generator
// assumes a 32-bit apb slave with byte addresses on word boundaries
package cpg_pkg;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 8;
  // register byte offsets
  localparam logic [7:0]  OFF_GEN    = 8'h00; // generator_control_reg
  localparam logic [7:0]  OFF_OUT    = 8'h04; // output_control_reg
  localparam logic [7:0]  OFF_DUTY   = 8'h08; // duty_value
  localparam logic [7:0]  OFF_MDUTY  = 8'h0c; // master duty
  localparam logic [7:0]  OFF_PHASE  = 8'h10; // phase_period_value
  localparam logic [7:0]  OFF_MPER   = 8'h14; // master period
  localparam logic [7:0]  OFF_DT     = 8'h18; // primary_dead_time
  localparam logic [7:0]  OFF_ADT    = 8'h1c; // alternate_dead_time
  localparam logic [7:0]  OFF_FLT    = 8'h20; // fault_limit_control_reg
  localparam logic [7:0]  OFF_TB2    = 8'h24; // time_base_control2_reg
  localparam logic [7:0]  OFF_TRIG   = 8'h28; // generator_trigger compare
  localparam logic [7:0]  OFF_STAT   = 8'h2c; // interrupt status, read clears
  localparam logic [7:0]  OFF_MASK   = 8'h30; // interrupt mask
  localparam logic [7:0]  OFF_CNT    = 8'h34; // counter and dead-time output state
  // generator_control_reg fields
  localparam int unsigned B_IMMED    = 0;
  localparam int unsigned B_CRESET   = 1;
  localparam int unsigned B_CENTER   = 2;
  localparam int unsigned B_MDSEL    = 8;
  localparam int unsigned B_ITB      = 9;
  localparam int unsigned B_ENABLE   = 15;
  // output_control_reg fields
  localparam int unsigned B_OSYNC    = 0;
  localparam int unsigned B_OVDL     = 6;
  localparam int unsigned B_OVDH     = 7;
  localparam int unsigned B_OVRL     = 8;
  localparam int unsigned B_OVRH     = 9;
  localparam int unsigned B_PMOD_LO  = 10;
  // fault_limit_control_reg field
  localparam int unsigned B_LIMIT_SOURCE_SELECT_LO = 10;
  localparam int unsigned LIMIT_SOURCE_SELECT_W    = 5;
  localparam int unsigned NSRC       = 32;
  // output modes
  localparam logic [1:0]  PMOD_COMP  = 2'h0;
  localparam logic [1:0]  PMOD_PP    = 2'h1;
  localparam logic [1:0]  PMOD_RED   = 2'h2;
  // status bits
  localparam int unsigned S_PERIOD   = 0;
  localparam int unsigned S_TRIG     = 1;
  localparam int unsigned S_CRESET   = 2;
  localparam int unsigned S_SEVT     = 3;
  localparam int unsigned NSTAT      = 4;
  localparam logic [CNT_W-1:0] ONE   = 16'h0001;
  localparam logic [CNT_W-1:0] ZERO  = 16'h0000;
endpackage : cpg_pkg

// ==== cpg_stage_model.sv ====
// cpg_stage_model.sv: gate drivers and current comparator beside the generator
// assumes pclk domain; a one-cycle fire strobe asks for one limit pulse
`timescale 1ns/10ps
module cpg_stage_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [4:0]  src,
  input  wire logic [3:0]  width,
  input  wire logic        high_output,
  input  wire logic        low_output,
  output logic      [31:0] limit_sources,
  output logic      [15:0] shoot_count
);
  logic [3:0] left_reg;
  logic [4:0] src_reg;
  // comparator pulse, width cycles long on the limit source chosen by src
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_reg <= 4'h0;
      src_reg  <= 5'h00;
    end
    else if (fire)
    begin
      left_reg <= width;
      src_reg  <= src;
    end
    else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
  end
  assign limit_sources = (left_reg != 4'h0) ? (32'h1 << src_reg) : 32'h0;
  // shoot-through watch: both switches of the leg on at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) shoot_count <= 16'h0000;
    else if (high_output && low_output) shoot_count <= shoot_count + 16'h1;
  end
endmodule : cpg_stage_model

// ==== cpg_sync.sv ====
// cpg_sync.sv: two flip-flop synchroniser for one pin
// assumes pclk domain, asynchronous active-low reset
`timescale 1ns/10ps
module cpg_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : cpg_sync

// ==== cpg_top.sv ====
// cpg_top.sv: complementary pwm generator channel with apb registers
// assumes apb master on pclk; limit sources and event pin are asynchronous
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
module cpg_top
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cpg_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [cpg_pkg::NSRC-1:0]    limit_sources,
  input  wire logic                        special_event_in,
  output logic                             high_output,
  output logic                             low_output,
  output logic                             generator_trigger,
  output logic                             irq
);
  localparam int unsigned W = cpg_pkg::CNT_W;

  logic [15:0]  generator_control_reg;
  logic [15:0]  output_control_reg;
  logic [W-1:0] duty_reg;
  logic [W-1:0] mduty_reg;
  logic [W-1:0] phase_reg;
  logic [W-1:0] mper_reg;
  logic [W-1:0] dt_reg;
  logic [W-1:0] adt_reg;
  logic [15:0]  fault_limit_control_reg;
  logic [2:0]   time_base_control2_reg;
  logic [W-1:0] trig_reg;
  logic [cpg_pkg::NSTAT-1:0] stat_reg;
  logic [cpg_pkg::NSTAT-1:0] mask_reg;
  logic [W-1:0] cnt_reg;
  logic         down_reg;
  logic [W-1:0] active_duty_reg;
  logic [11:0]  ovr_active_reg;
  logic         cr_last_reg;
  logic         sev_last_reg;
  logic         raw_h;
  logic         dt_h;
  logic         dt_l;
  logic         cr_sync;
  logic [cpg_pkg::NSRC-1:0] lim_sync;
  logic         pp_odd_reg;
  logic         sev_sync;

  // bus decode
  logic         wr_en;
  logic         rd_en;
  logic         mapped;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite; // read data is sampled in setup

  // control field views
  logic         enable;
  logic         independent_time_base;
  logic         center;
  logic [1:0]   pmod;
  logic [W-1:0] period;
  logic [W-1:0] sel_duty;
  logic         boundary;
  logic         cr_event;
  logic         sev_event;
  logic [cpg_pkg::LIMIT_SOURCE_SELECT_W-1:0] limit_source_select;
  assign enable = generator_control_reg[cpg_pkg::B_ENABLE];
  assign independent_time_base    = generator_control_reg[cpg_pkg::B_ITB];
  assign center = generator_control_reg[cpg_pkg::B_CENTER];
  assign pmod   = output_control_reg[cpg_pkg::B_PMOD_LO +: 2];
  assign limit_source_select  = fault_limit_control_reg[cpg_pkg::B_LIMIT_SOURCE_SELECT_LO +: cpg_pkg::LIMIT_SOURCE_SELECT_W];
  assign period = independent_time_base ? phase_reg : mper_reg;
  assign sel_duty = generator_control_reg[cpg_pkg::B_MDSEL] ? mduty_reg : duty_reg;
  assign boundary = enable && (center ? (down_reg && cnt_reg == cpg_pkg::ZERO)
                                      : (cnt_reg >= period));
  assign cr_sync = lim_sync[limit_source_select];
  assign cr_event = cr_sync && !cr_last_reg;
  assign sev_event = sev_sync && !sev_last_reg;

  // every limit source and the special event pass two flops
  for (genvar i = 0; i < cpg_pkg::NSRC; i++)
  begin : g_lim
    cpg_sync u_lim_sync (.pclk(pclk), .presetn(presetn), .ce(ce),
                         .d(limit_sources[i]), .q(lim_sync[i]));
  end
  cpg_sync u_sev_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (special_event_in),
    .q       (sev_sync)
  );

  // apb write side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      generator_control_reg  <= 16'h0000;
      output_control_reg     <= 16'h0000;
      duty_reg               <= cpg_pkg::ZERO;
      mduty_reg              <= cpg_pkg::ZERO;
      phase_reg              <= cpg_pkg::ZERO;
      mper_reg               <= cpg_pkg::ZERO;
      dt_reg                 <= cpg_pkg::ZERO;
      adt_reg                <= cpg_pkg::ZERO;
      fault_limit_control_reg <= 16'h0000;
      time_base_control2_reg <= 3'h0;
      trig_reg               <= cpg_pkg::ZERO;
      mask_reg               <= '0;
    end
    else if (ce && wr_en)
    begin
      case (paddr)
        cpg_pkg::OFF_GEN:   generator_control_reg  <= pwdata[15:0];
        cpg_pkg::OFF_OUT:   output_control_reg     <= pwdata[15:0];
        cpg_pkg::OFF_DUTY:  duty_reg               <= pwdata[W-1:0];
        cpg_pkg::OFF_MDUTY: mduty_reg              <= pwdata[W-1:0];
        cpg_pkg::OFF_PHASE: phase_reg              <= pwdata[W-1:0];
        cpg_pkg::OFF_MPER:  mper_reg               <= pwdata[W-1:0];
        cpg_pkg::OFF_DT:    dt_reg                 <= pwdata[W-1:0];
        cpg_pkg::OFF_ADT:   adt_reg                <= pwdata[W-1:0];
        cpg_pkg::OFF_FLT:   fault_limit_control_reg <= pwdata[15:0];
        cpg_pkg::OFF_TB2:   time_base_control2_reg <= pwdata[2:0];
        cpg_pkg::OFF_TRIG:  trig_reg               <= pwdata[W-1:0];
        cpg_pkg::OFF_MASK:  mask_reg               <= pwdata[cpg_pkg::NSTAT-1:0];
        default:            mask_reg               <= mask_reg;
      endcase
    end
  end

  // address map check
  always_comb
  begin
    case (paddr)
      cpg_pkg::OFF_GEN, cpg_pkg::OFF_OUT, cpg_pkg::OFF_DUTY, cpg_pkg::OFF_MDUTY,
      cpg_pkg::OFF_PHASE, cpg_pkg::OFF_MPER, cpg_pkg::OFF_DT, cpg_pkg::OFF_ADT,
      cpg_pkg::OFF_FLT, cpg_pkg::OFF_TB2, cpg_pkg::OFF_TRIG, cpg_pkg::OFF_STAT,
      cpg_pkg::OFF_MASK, cpg_pkg::OFF_CNT: mapped = 1'b1;
      default:                             mapped = 1'b0;
    endcase
  end

  // apb read side, zero wait state answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          cpg_pkg::OFF_GEN:   prdata <= {16'h0000, generator_control_reg};
          cpg_pkg::OFF_OUT:   prdata <= {16'h0000, output_control_reg};
          cpg_pkg::OFF_DUTY:  prdata <= {16'h0000, duty_reg};
          cpg_pkg::OFF_MDUTY: prdata <= {16'h0000, mduty_reg};
          cpg_pkg::OFF_PHASE: prdata <= {16'h0000, phase_reg};
          cpg_pkg::OFF_MPER:  prdata <= {16'h0000, mper_reg};
          cpg_pkg::OFF_DT:    prdata <= {16'h0000, dt_reg};
          cpg_pkg::OFF_ADT:   prdata <= {16'h0000, adt_reg};
          cpg_pkg::OFF_FLT:   prdata <= {16'h0000, fault_limit_control_reg};
          cpg_pkg::OFF_TB2:   prdata <= {29'h0000_0000, time_base_control2_reg};
          cpg_pkg::OFF_TRIG:  prdata <= {16'h0000, trig_reg};
          cpg_pkg::OFF_STAT:  prdata <= {28'h000_0000, stat_reg};
          cpg_pkg::OFF_MASK:  prdata <= {28'h000_0000, mask_reg};
          cpg_pkg::OFF_CNT:   prdata <= {14'h0000, dt_h, dt_l, cnt_reg};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // time base counter, edge or centre aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg  <= cpg_pkg::ZERO;
      down_reg <= 1'b0;
      pp_odd_reg <= 1'b0;
    end
    else if (ce)
    begin
      pp_odd_reg <= enable && (pp_odd_reg ^ boundary);
      if (!enable)
      begin
        cnt_reg  <= cpg_pkg::ZERO;
        down_reg <= 1'b0;
      end
      else if (generator_control_reg[cpg_pkg::B_CRESET] && independent_time_base && cr_event)
      begin
        cnt_reg  <= cpg_pkg::ZERO;
        down_reg <= 1'b0;
      end
      else if (center)
      begin
        if (!down_reg && cnt_reg >= period)
          down_reg <= 1'b1;
        else if (down_reg && cnt_reg == cpg_pkg::ZERO)
          down_reg <= 1'b0;
        else if (down_reg)
          cnt_reg <= cnt_reg - cpg_pkg::ONE;
        else
          cnt_reg <= cnt_reg + cpg_pkg::ONE;
      end
      else if (cnt_reg >= period)
        cnt_reg <= cpg_pkg::ZERO;
      else
        cnt_reg <= cnt_reg + cpg_pkg::ONE;
    end
  end

  // active duty loads at once or on the boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_duty_reg <= cpg_pkg::ZERO;
    else if (ce)
    begin
      if (generator_control_reg[cpg_pkg::B_IMMED] || boundary || !enable)
        active_duty_reg <= sel_duty;
    end
  end

  // override settings apply immediately or on the boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_active_reg <= 12'h000;
    else if (ce)
    begin
      if (!output_control_reg[cpg_pkg::B_OSYNC] || boundary || !enable)
        ovr_active_reg <= output_control_reg[11:0];
    end
  end

  // raw high drive: duty above counter; phase+1 or +2 gives full period
  assign raw_h = center ? ({1'b0, cnt_reg} + 17'h00001 < {1'b0, active_duty_reg})
                        : (cnt_reg < active_duty_reg);

  cpg_deadtime u_dead
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .raw     (raw_h && enable),
    .dt_rise (dt_reg),
    .dt_fall (center ? dt_reg : adt_reg),
    .hi      (dt_h),
    .lo      (dt_l)
  );

  // output mode, override and pin registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_output <= 1'b0;
      low_output  <= 1'b0;
    end
    else if (ce)
    begin
      case (pmod)
        cpg_pkg::PMOD_RED:
        begin
          high_output <= raw_h && enable;
          low_output  <= raw_h && enable;
        end
        cpg_pkg::PMOD_PP:
        begin
          high_output <= raw_h && enable && !pp_odd_reg;
          low_output  <= raw_h && enable && pp_odd_reg;
        end
        default:
        begin
          high_output <= dt_h;
          low_output  <= dt_l;
        end
      endcase
      if (ovr_active_reg[cpg_pkg::B_OVRH])
        high_output <= ovr_active_reg[cpg_pkg::B_OVDH];
      if (ovr_active_reg[cpg_pkg::B_OVRL])
        low_output  <= ovr_active_reg[cpg_pkg::B_OVDL];
    end
  end

  // trigger pulse, edge history and sticky status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      generator_trigger <= 1'b0;
      cr_last_reg       <= 1'b0;
      sev_last_reg      <= 1'b0;
      stat_reg          <= '0;
      irq               <= 1'b0;
    end
    else if (ce)
    begin
      cr_last_reg       <= cr_sync;
      sev_last_reg      <= sev_sync;
      generator_trigger <= enable && (cnt_reg == trig_reg);
      // status read clears; a new event in the same cycle wins
      stat_reg <= ((rd_en && paddr == cpg_pkg::OFF_STAT) ? '0 : stat_reg)
                | {sev_event, cr_event, enable && cnt_reg == trig_reg, boundary};
      irq <= |(stat_reg & mask_reg);
    end
  end
endmodule : cpg_top

// ==== cpg_top_sva.sv ====
// cpg_top_sva.sv: port-level assertions for the pwm generator channel
// assumes binding to cpg_top; shadows a few fields from apb writes
`timescale 1ns/10ps
module cpg_top_sva
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       ce,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [cpg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       high_output,
  input wire logic                       low_output
);
  logic        touched_reg;
  logic        en_reg;
  logic [15:0] dt_reg;
  logic [15:0] adt_reg;
  logic        wr_done;
  logic        gap_ok;
  logic        setup;
  assign wr_done = psel && penable && pready && pwrite;
  assign setup   = psel && !penable && ce;
  assign gap_ok  = !touched_reg && en_reg && dt_reg == 16'h0002 && adt_reg == 16'h0002;
  // shadow of enable, dead times and any output_control write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      touched_reg <= 1'b0;
      en_reg      <= 1'b0;
      dt_reg      <= 16'h0000;
      adt_reg     <= 16'h0000;
    end
    else if (wr_done)
    begin
      if (paddr == cpg_pkg::OFF_OUT) touched_reg <= 1'b1;
      if (paddr == cpg_pkg::OFF_GEN) en_reg <= pwdata[cpg_pkg::B_ENABLE];
      if (paddr == cpg_pkg::OFF_DT) dt_reg <= pwdata[15:0];
      if (paddr == cpg_pkg::OFF_ADT) adt_reg <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  a_ready_follows: assert property (disable iff (!presetn) setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (disable iff (!presetn) pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (disable iff (!presetn) pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (disable iff (!presetn) setup && paddr > 8'h34 |=> pslverr)
    else $error("unmapped address not refused");
  a_mapped_clean: assert property (disable iff (!presetn)
    setup && paddr <= 8'h34 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  a_unmapped_zero: assert property (disable iff (!presetn)
    setup && !pwrite && paddr > 8'h34 |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (!presetn |-> !high_output && !low_output && !pready)
    else $error("outputs active in reset");
  a_no_overlap: assert property (disable iff (!presetn)
    !touched_reg |-> !(high_output && low_output))
    else $error("both gates on");
  a_gap_after_hi: assert property (disable iff (!presetn)
    gap_ok && $fell(high_output) |-> !low_output [*2])
    else $error("low rose inside dead time");
  a_gap_after_lo: assert property (disable iff (!presetn)
    gap_ok && $fell(low_output) |-> !high_output [*2])
    else $error("high rose inside dead time");
endmodule : cpg_top_sva

bind cpg_top cpg_top_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .high_output(high_output), .low_output(low_output));

// ==== cpg_top_tb.sv ====
// cpg_top_tb.sv: self-checking bench for the pwm generator channel
// assumes cpg_pkg, cpg_top, cpg_stage_model and the bound checker compiled first
`timescale 1ns/10ps
module cpg_top_tb;
  typedef struct { logic [31:0] gen; logic [31:0] duty; logic [31:0] hi40; } cpg_row_t;
  localparam logic [31:0] EN = 32'h8000, INDEPENDENT_TIME_BASE = 32'h0200, IMM = 32'h0001;
  logic        pclk, presetn, ce, psel, penable, pwrite, fire, sev, err;
  logic        pready, pslverr, hi, lo, trig, irq;
  logic [4:0]  src;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lim, h, l;
  logic [15:0] shoot;
  int          bad_count, checks_done, n;
  cpg_row_t    rows [7] = '{'{EN|INDEPENDENT_TIME_BASE|IMM, 32'h4, 32'h10}, '{EN|INDEPENDENT_TIME_BASE|IMM, 32'ha, 32'h28},
    '{EN|INDEPENDENT_TIME_BASE|IMM|32'h100, 32'h4, 32'hc}, '{EN|IMM, 32'h2, 32'h10},
    '{EN|INDEPENDENT_TIME_BASE|IMM|32'h4, 32'hb, 32'h28}, '{EN|INDEPENDENT_TIME_BASE|IMM|32'h4, 32'h0, 32'h0},
    '{32'h0, 32'h4, 32'h0}};
  cpg_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .limit_sources(lim), .special_event_in(sev), .high_output(hi),
    .low_output(lo), .generator_trigger(trig), .irq(irq));
  cpg_stage_model u_stage (.pclk(pclk), .presetn(presetn), .fire(fire), .src(src),
    .width(4'h3), .high_output(hi), .low_output(lo), .limit_sources(lim),
    .shoot_count(shoot));
  // free-running 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // one apb transfer; holds the request until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) bad_count++;
  endtask : apb
  task automatic count_pins(input int cyc);
    h = 0;
    l = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      h = h + 32'(hi);
      l = l + 32'(lo);
    end
  endtask : count_pins
  task automatic pulse(input logic [4:0] s);
    @(posedge pclk);
    src  <= s;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, cpg_pkg::OFF_CNT, 32'h0);
  endtask : pulse
  // watchdog over the whole run
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, fire, sev} = 6'h00;
    ce = 1'b1;
    {paddr, pwdata, src} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 14; n++)
    begin
      apb(1'b0, 8'(n * 4), 32'h0);
      // a disabled pair rests with the low side on
      check(rd, (n == 13) ? 32'h0001_0000 : 32'h0);
    end
    $display("test reset values done");
    apb(1'b1, cpg_pkg::OFF_PHASE, 32'h9);
    apb(1'b1, cpg_pkg::OFF_MDUTY, 32'h3);
    apb(1'b1, cpg_pkg::OFF_MPER, 32'h4);
    apb(1'b0, cpg_pkg::OFF_MPER, 32'h0);
    check(rd, 32'h4);
    foreach (rows[i])
    begin
      apb(1'b1, cpg_pkg::OFF_DUTY, rows[i].duty);
      apb(1'b1, cpg_pkg::OFF_GEN, rows[i].gen);
      repeat (30) @(posedge pclk);
      count_pins(40);
      check(h, rows[i].hi40);
    end
    $display("test duty table done");
    apb(1'b1, cpg_pkg::OFF_DT, 32'h2);
    apb(1'b1, cpg_pkg::OFF_ADT, 32'h2);
    apb(1'b1, cpg_pkg::OFF_DUTY, 32'h5);
    apb(1'b1, cpg_pkg::OFF_GEN, EN | INDEPENDENT_TIME_BASE | IMM);
    repeat (30) @(posedge pclk);
    count_pins(80);
    check(h + l, 32'd48);
    check(32'(shoot), 32'h0);
    $display("test dead time done");
    apb(1'b1, cpg_pkg::OFF_PHASE, 32'd200);
    apb(1'b1, cpg_pkg::OFF_DUTY, 32'd20);
    apb(1'b1, cpg_pkg::OFF_FLT, 32'h1c00);
    apb(1'b1, cpg_pkg::OFF_MASK, 32'h4);
    apb(1'b1, cpg_pkg::OFF_GEN, EN | INDEPENDENT_TIME_BASE | IMM | 32'h2);
    repeat (50) @(posedge pclk);
    pulse(5'd7);
    check(32'(rd[15:0] < 16'd16), 32'h1);
    check(32'(irq), 32'h1);
    apb(1'b0, cpg_pkg::OFF_STAT, 32'h0);
    check(32'(rd[2]), 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    repeat (50) @(posedge pclk);
    pulse(5'd3);
    check(32'(rd[15:0] > 16'd16), 32'h1);
    apb(1'b1, cpg_pkg::OFF_GEN, EN | INDEPENDENT_TIME_BASE | IMM);
    pulse(5'd7);
    check(32'(rd[15:0] > 16'd16), 32'h1);
    $display("test current reset done");
    apb(1'b1, cpg_pkg::OFF_TRIG, 32'h5);
    for (n = 0; n < 250 && trig !== 1'b1; n++) @(posedge pclk);
    check(32'(trig), 32'h1);
    sev <= 1'b1;
    repeat (3) @(posedge pclk);
    sev <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, cpg_pkg::OFF_STAT, 32'h0);
    check(32'(rd[3]), 32'h1);
    $display("test triggers done");
    repeat (30) @(posedge pclk);
    apb(1'b1, cpg_pkg::OFF_OUT, 32'h381);
    repeat (5) @(posedge pclk);
    check(32'(hi), 32'h0);
    repeat (210) @(posedge pclk);
    check(32'({hi, lo}), 32'h2);
    apb(1'b1, cpg_pkg::OFF_OUT, 32'h340);
    repeat (3) @(posedge pclk);
    check(32'({hi, lo}), 32'h1);
    apb(1'b1, cpg_pkg::OFF_OUT, 32'h280);
    repeat (3) @(posedge pclk);
    check(32'(hi), 32'h1);
    $display("test override done");
    apb(1'b1, cpg_pkg::OFF_DUTY, 32'd100);
    for (n = 1; n < 3; n++)
    begin
      apb(1'b1, cpg_pkg::OFF_OUT, 32'(n) << cpg_pkg::B_PMOD_LO);
      repeat (30) @(posedge pclk);
      count_pins(804);
      check(h, 32'd200 * 32'(n));
      check(l, 32'd200 * 32'(n));
    end
    $display("test output modes done");
    apb(1'b0, cpg_pkg::OFF_CNT, 32'h0);
    h = rd;
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, cpg_pkg::OFF_CNT, 32'h0);
    check((rd[15:0] + 32'd201 - h[15:0]) % 32'd201, 32'h3);
    $display("test clock enable done");
    apb(1'b1, 8'h40, 32'h5a);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check(32'({hi, lo, irq}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, cpg_pkg::OFF_GEN, 32'h0);
    check(rd, 32'h0);
    $display("test refusal and reset done");
    give_verdict();
  end
endmodule : cpg_top_tb
